/* File: pkg/dos_pkg.sv */
package dos_pkg;
  // terminal count and field widths
  localparam int NUM_OUT = 3;
  localparam int CODE_W = 6;
  localparam int FREQ_W = 14;
  localparam int FWID_W = 8;
  localparam int VOLT_W = 12;
  localparam int PCT_W = 7;
  localparam int SRC_W = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_SEL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SEL1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SEL2 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FDET_LEVEL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FDET_WIDTH = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LV_LEVEL = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SRC_CFG = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_LOSS_PCT = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_COMM_DO = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_LOSS_REF = 8'h28;
  localparam logic [ADDR_W-1:0] WORD_MASK = 8'h03;

  // source config field positions
  localparam int SRC_RUN_LSB = 0;
  localparam int SRC_REF_LSB = 2;
  localparam int SRC_LOSS_BIT = 4;
  // status field positions
  localparam int ST_DET_BIT = 3;
  localparam int ST_STOP_BIT = 4;

  // reset values and the full-scale percentage
  localparam logic [CODE_W-1:0] RST_SEL = 6'h3f;
  localparam logic [FREQ_W-1:0] RST_LEVEL = 14'h0000;
  localparam logic [FWID_W-1:0] RST_WIDTH = 8'h14;
  localparam logic [VOLT_W-1:0] RST_LV = 12'h000;
  localparam logic [PCT_W-1:0] RST_PCT = 7'h64;
  localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;

  // function codes
  localparam logic [CODE_W-1:0] FN_RUNNING = 6'h00;
  localparam logic [CODE_W-1:0] FN_FAULT = 6'h01;
  localparam logic [CODE_W-1:0] FN_FAGREE = 6'h02;
  localparam logic [CODE_W-1:0] FN_SET_AGREE = 6'h03;
  localparam logic [CODE_W-1:0] FN_FDET1 = 6'h04;
  localparam logic [CODE_W-1:0] FN_FDET2 = 6'h05;
  localparam logic [CODE_W-1:0] FN_RESTART = 6'h06;
  localparam logic [CODE_W-1:0] FN_BLOCKED = 6'h09;
  localparam logic [CODE_W-1:0] FN_OVER_TQ = 6'h0c;
  localparam logic [CODE_W-1:0] FN_PLC_SRC = 6'h12;
  localparam logic [CODE_W-1:0] FN_PLC_CTL = 6'h13;
  localparam logic [CODE_W-1:0] FN_ZERO_SPD = 6'h14;
  localparam logic [CODE_W-1:0] FN_READY = 6'h15;
  localparam logic [CODE_W-1:0] FN_UNDERVOLT = 6'h16;
  localparam logic [CODE_W-1:0] FN_RUN_LOCAL = 6'h17;
  localparam logic [CODE_W-1:0] FN_REF_LOCAL = 6'h18;
  localparam logic [CODE_W-1:0] FN_UNDER_TQ = 6'h19;
  localparam logic [CODE_W-1:0] FN_REF_LOSS = 6'h1a;
  localparam logic [CODE_W-1:0] FN_TRAV_UP = 6'h1c;
  localparam logic [CODE_W-1:0] FN_TRAV_ON = 6'h1d;
  localparam logic [CODE_W-1:0] FN_MOTOR2 = 6'h1e;
  localparam logic [CODE_W-1:0] FN_ZSERVO = 6'h1f;
  localparam logic [CODE_W-1:0] FN_COMM = 6'h20;

  // source setting values
  localparam logic [SRC_W-1:0] SRC_LOCAL = 2'h0;
  localparam logic [SRC_W-1:0] SRC_PLC = 2'h3;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [DATA_W-1:0] pwdata;
  } dos_apb_req_t;

  typedef struct packed {
    logic run_cmd;
    logic fault_active;
    logic comm_error_first;
    logic comm_error_second;
    logic auto_restart;
    logic output_blocked;
    logic over_torque;
    logic under_torque;
    logic plc_result;
    logic drive_ready;
    logic local_remote_in;
    logic ref_loss;
    logic traverse_up;
    logic traverse_on;
    logic motor2_sel;
    logic zero_servo_done;
    logic [FREQ_W-1:0] out_freq;
    logic [FREQ_W-1:0] freq_ref;
    logic [FREQ_W-1:0] min_freq;
    logic [VOLT_W-1:0] dc_bus;
  } dos_status_t;
endpackage : dos_pkg

/* File: hw/dos_select.sv */
// The implementer's own choices: the APB interface to the registers and the register addresses.
module dos_select (
  input wire logic clk,
  input wire logic rst,
  input wire dos_pkg::dos_apb_req_t apb_req,
  output logic [dos_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dos_pkg::dos_status_t drv_status,
  output logic [dos_pkg::NUM_OUT-1:0] out_contact,
  output logic loss_stop_req,
  output logic [dos_pkg::FREQ_W-1:0] loss_run_ref
);
  import dos_pkg::*;

  localparam int COND_W = 33;

  // pick the condition for a function code; reserved codes read zero
  function automatic logic sel_cond(input logic [CODE_W-1:0] code,
                                    input logic [COND_W-1:0] cond,
                                    input logic comm_bit);
    logic r;
    r = 1'b0;
    if (code == FN_COMM) begin
      r = comm_bit;
    end else if (code < FN_COMM) begin
      r = cond[code[4:0]];
    end
    return r;
  endfunction : sel_cond

  // register storage
  logic [CODE_W-1:0] sel_r [NUM_OUT];
  logic [FREQ_W-1:0] level_r;
  logic [FWID_W-1:0] width_r;
  logic [VOLT_W-1:0] lv_r;
  logic [SRC_W-1:0] run_src_r;
  logic [SRC_W-1:0] ref_src_r;
  logic loss_act_r;
  logic [PCT_W-1:0] pct_r;
  logic [NUM_OUT-1:0] comm_r;
  logic det_hi_r;
  logic [FREQ_W-1:0] last_ref_r;
  logic [NUM_OUT-1:0] out_r;
  logic stop_r;
  logic [FREQ_W-1:0] lref_r;
  logic [DATA_W-1:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // bus phase decode
  wire setup_ph = apb_req.psel & ~apb_req.penable;
  wire wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
  wire [ADDR_W-1:0] addr = apb_req.paddr;
  wire [DATA_W-1:0] wd = apb_req.pwdata;
  wire word_ok = (addr & WORD_MASK) == '0;
  wire [ADDR_W-1:0] sel_base = OFS_SEL0;
  wire sel_hit = word_ok & (addr >= OFS_SEL0) & (addr <= OFS_SEL2);
  wire [1:0] sel_idx = 2'((addr - sel_base) >> 2);
  wire hit_level = addr == OFS_FDET_LEVEL;
  wire hit_width = addr == OFS_FDET_WIDTH;
  wire hit_lv = addr == OFS_LV_LEVEL;
  wire hit_src = addr == OFS_SRC_CFG;
  wire hit_pct = addr == OFS_LOSS_PCT;
  wire hit_comm = addr == OFS_COMM_DO;
  wire hit_stat = addr == OFS_STATUS;
  wire hit_lref = addr == OFS_LOSS_REF;
  wire mapped = sel_hit | hit_level | hit_width | hit_lv | hit_src | hit_pct
    | hit_comm | hit_stat | hit_lref;

  // frequency comparisons, one bit wider to hold sums
  wire [FREQ_W:0] fout = {1'b0, drv_status.out_freq};
  wire [FREQ_W:0] fref = {1'b0, drv_status.freq_ref};
  wire [FREQ_W:0] flev = {1'b0, level_r};
  wire [FREQ_W:0] fwid = {{(FREQ_W+1-FWID_W){1'b0}}, width_r};
  wire [FREQ_W:0] lev_hi = flev + fwid;
  wire [FREQ_W:0] lev_lo = (flev > fwid) ? flev - fwid : '0;
  wire [FREQ_W:0] ref_lo = (fref > fwid) ? fref - fwid : '0;
  wire agree = (fout >= ref_lo) & (fout <= fref);
  wire set_agree = (fout >= lev_lo) & (fout <= lev_hi);
  wire above_hi = fout >= lev_hi;
  wire below_lev = fout < flev;

  // hysteresis: set at level+width, cleared under level
  wire det_nxt = above_hi ? 1'b1 : (below_lev ? 1'b0 : det_hi_r);

  // command source decoding
  wire lr = drv_status.local_remote_in;
  wire run_local = (run_src_r == SRC_LOCAL) | lr;
  wire ref_local = (ref_src_r == SRC_LOCAL) | lr;
  wire comm_fault = drv_status.comm_error_first | drv_status.comm_error_second;
  wire fault_out = drv_status.fault_active & ~comm_fault;

  // condition vector indexed by function code
  logic [COND_W-1:0] cond;
  always_comb begin
    cond = '0;
    cond[FN_RUNNING] = drv_status.run_cmd | (drv_status.out_freq != '0);
    cond[FN_FAULT] = fault_out;
    cond[FN_FAGREE] = agree;
    cond[FN_SET_AGREE] = set_agree;
    cond[FN_FDET1] = det_nxt;
    cond[FN_FDET2] = ~det_nxt;
    cond[FN_RESTART] = drv_status.auto_restart;
    cond[FN_BLOCKED] = drv_status.output_blocked;
    cond[FN_OVER_TQ] = drv_status.over_torque;
    cond[FN_UNDER_TQ] = drv_status.under_torque;
    cond[FN_PLC_SRC] = run_src_r == SRC_PLC;
    cond[FN_PLC_CTL] = drv_status.plc_result;
    cond[FN_ZERO_SPD] = drv_status.out_freq < drv_status.min_freq;
    cond[FN_READY] = drv_status.drive_ready & ~drv_status.fault_active;
    cond[FN_UNDERVOLT] = drv_status.dc_bus < lv_r;
    cond[FN_RUN_LOCAL] = run_local;
    cond[FN_REF_LOCAL] = ref_local;
    cond[FN_REF_LOSS] = drv_status.ref_loss;
    cond[FN_TRAV_UP] = drv_status.traverse_up;
    cond[FN_TRAV_ON] = drv_status.traverse_on;
    cond[FN_MOTOR2] = drv_status.motor2_sel;
    cond[FN_ZSERVO] = drv_status.zero_servo_done;
  end

  // per-terminal selection and selector storage
  logic [NUM_OUT-1:0] out_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_term
      assign out_nxt[gi] = sel_cond(sel_r[gi], cond, comm_r[gi]);
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sel_r[gi] <= RST_SEL;
        end else if (wr_en & sel_hit & (sel_idx == 2'(gi))) begin
          sel_r[gi] <= wd[CODE_W-1:0];
        end
      end
    end
  endgenerate

  // reference loss handling: continue at fraction of last good reference
  wire [FREQ_W+PCT_W-1:0] scaled = drv_status.freq_ref * pct_r;
  wire [FREQ_W+PCT_W-1:0] lscaled = last_ref_r * pct_r;
  wire [FREQ_W-1:0] lref_nxt = FREQ_W'(lscaled / PCT_FULL);
  wire stop_nxt = drv_status.ref_loss & ~loss_act_r;
  wire [FREQ_W-1:0] cont_nxt = (drv_status.ref_loss & loss_act_r) ? lref_nxt
    : FREQ_W'(scaled / PCT_FULL);

  // configuration registers written in the access phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_r <= RST_LEVEL;
      width_r <= RST_WIDTH;
      lv_r <= RST_LV;
      run_src_r <= SRC_LOCAL;
      ref_src_r <= SRC_LOCAL;
      loss_act_r <= 1'b0;
      pct_r <= RST_PCT;
      comm_r <= '0;
    end else if (wr_en) begin
      if (hit_level) level_r <= wd[FREQ_W-1:0];
      if (hit_width) width_r <= wd[FWID_W-1:0];
      if (hit_lv) lv_r <= wd[VOLT_W-1:0];
      if (hit_src) begin
        run_src_r <= wd[SRC_RUN_LSB +: SRC_W];
        ref_src_r <= wd[SRC_REF_LSB +: SRC_W];
        loss_act_r <= wd[SRC_LOSS_BIT];
      end
      if (hit_pct) pct_r <= wd[PCT_W-1:0];
      if (hit_comm) comm_r <= wd[NUM_OUT-1:0];
    end
  end

  // drive-side state and registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      det_hi_r <= 1'b0;
      last_ref_r <= '0;
      out_r <= '0;
      stop_r <= 1'b0;
      lref_r <= '0;
    end else begin
      det_hi_r <= det_nxt;
      if (!drv_status.ref_loss) last_ref_r <= drv_status.freq_ref;
      out_r <= out_nxt;
      stop_r <= stop_nxt;
      lref_r <= cont_nxt;
    end
  end

  // read mux
  logic [DATA_W-1:0] rd_nxt;
  always_comb begin
    rd_nxt = '0;
    if (sel_hit) rd_nxt[CODE_W-1:0] = sel_r[sel_idx];
    if (hit_level) rd_nxt[FREQ_W-1:0] = level_r;
    if (hit_width) rd_nxt[FWID_W-1:0] = width_r;
    if (hit_lv) rd_nxt[VOLT_W-1:0] = lv_r;
    if (hit_src) begin
      rd_nxt[SRC_RUN_LSB +: SRC_W] = run_src_r;
      rd_nxt[SRC_REF_LSB +: SRC_W] = ref_src_r;
      rd_nxt[SRC_LOSS_BIT] = loss_act_r;
    end
    if (hit_pct) rd_nxt[PCT_W-1:0] = pct_r;
    if (hit_comm) rd_nxt[NUM_OUT-1:0] = comm_r;
    if (hit_stat) begin
      rd_nxt[NUM_OUT-1:0] = out_r;
      rd_nxt[ST_DET_BIT] = det_hi_r;
      rd_nxt[ST_STOP_BIT] = stop_r;
    end
    if (hit_lref) rd_nxt[FREQ_W-1:0] = lref_r;
  end

  // apb answer: data and error captured in setup, zero wait states
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
      if (setup_ph) begin
        prdata_r <= rd_nxt;
        pslverr_r <= ~mapped;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign out_contact = out_r;
  assign loss_stop_req = stop_r;
  assign loss_run_ref = lref_r;
endmodule : dos_select

/* File: bench/dos_select_properties.sv */
module dos_select_properties (
  input wire logic clk,
  input wire logic rst,
  input wire dos_pkg::dos_apb_req_t apb_req,
  input wire logic [dos_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire dos_pkg::dos_status_t drv_status,
  input wire logic [dos_pkg::NUM_OUT-1:0] out_contact,
  input wire logic loss_stop_req,
  input wire logic [dos_pkg::FREQ_W-1:0] loss_run_ref
);
  timeunit 1ns;
  timeprecision 1ns;
  import dos_pkg::*;
  logic [CODE_W-1:0] sel_r;
  dos_status_t s;
  logic wr_sel0;
  // terminal 0 selector write decode
  assign s = drv_status;
  assign wr_sel0 = apb_req.psel && apb_req.penable && apb_req.pwrite && pready
    && apb_req.paddr == OFS_SEL0;
  // shadow copy of terminal 0 selector
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_r <= RST_SEL;
    end else if (wr_sel0) begin
      sel_r <= apb_req.pwdata[CODE_W-1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_run_contact: assert property (sel_r == FN_RUNNING |=>
    out_contact[0] == $past(s.run_cmd || s.out_freq != '0)) else $error("run contact");
  a_fault_contact: assert property (sel_r == FN_FAULT |=> out_contact[0] ==
    $past(s.fault_active && !s.comm_error_first && !s.comm_error_second)) else $error("fault");
  a_restart_contact: assert property (sel_r == FN_RESTART |=>
    out_contact[0] == $past(s.auto_restart)) else $error("restart contact");
  a_torque_contact: assert property (sel_r == FN_OVER_TQ |=>
    out_contact[0] == $past(s.over_torque)) else $error("torque contact");
  a_zero_speed: assert property (sel_r == FN_ZERO_SPD |=>
    out_contact[0] == $past(s.out_freq < s.min_freq)) else $error("zero speed contact");
  a_ready_contact: assert property (sel_r == FN_READY |=>
    out_contact[0] == $past(!s.fault_active && s.drive_ready)) else $error("ready contact");
  a_motor_two: assert property (sel_r == FN_MOTOR2 |=>
    out_contact[0] == $past(s.motor2_sel)) else $error("motor two contact");
  a_reserved_off: assert property ((sel_r == 6'h07 || sel_r > FN_COMM) [*2] |->
    !out_contact[0]) else $error("reserved code drives contact");
endmodule : dos_select_properties

bind dos_select dos_select_properties chk (.clk(clk), .rst(rst), .apb_req(apb_req),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .drv_status(drv_status),
  .out_contact(out_contact), .loss_stop_req(loss_stop_req), .loss_run_ref(loss_run_ref));

/* File: bench/dos_relay_load.sv */
module dos_relay_load (
  input wire logic clk,
  input wire logic rst,
  input wire logic [dos_pkg::NUM_OUT-1:0] coil,
  output logic [dos_pkg::NUM_OUT-1:0] closed
);
  timeunit 1ns;
  timeprecision 1ns;
  import dos_pkg::*;
  // relay contacts follow the coils a clock late, open in reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) closed <= '0;
    else closed <= coil;
  end
endmodule : dos_relay_load

/* File: bench/dos_select_test.sv */
module dos_select_test;
  timeunit 1ns;
  timeprecision 1ns;
  import dos_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  dos_apb_req_t apb_req = '0;
  dos_status_t st = '0;
  dos_status_t nx;
  logic [95:0] rn;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, loss_stop_req;
  logic [NUM_OUT-1:0] out_contact;
  logic [FREQ_W-1:0] loss_run_ref;
  logic [4:0] cfg;
  logic [11:0] lv;
  logic [2:0] comm;
  logic det_m = 1'b0;
  logic [FREQ_W-1:0] last_ref = '0;
  logic [FREQ_W-1:0] lref_exp;
  int miscompares = 0;
  int cmp_count = 0;
  logic [32:0] rd_q[$];
  logic [3:0] out_q[$];
  event chk_ev;
  localparam logic [CODE_W-1:0] CODES [29] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
    6'h06, 6'h09, 6'h0c,
    6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1c, 6'h1d, 6'h1e,
    6'h1f, 6'h20, 6'h07, 6'h08, 6'h0d, 6'h11, 6'h21, 6'h3f};

  always #10 clk = ~clk;

  dos_select dut (.clk(clk), .rst(rst), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drv_status(st), .out_contact(out_contact),
    .loss_stop_req(loss_stop_req), .loss_run_ref(loss_run_ref));
  dos_relay_load load (.clk(clk), .rst(rst), .coil(out_contact), .closed());

  // compare tasks, one per kind of result, and the end-of-run report
  task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] read exp %h got %h", e, g);
    end
  endtask : cmp_rd
  task automatic cmp_out(input logic [3:0] e, input logic [3:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] contacts exp %h got %h", e, g);
    end
  endtask : cmp_out
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    apb_req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, '0);
  endtask : rd

  // expected terminal 0 level for a code
  function automatic logic f0(input logic [5:0] c);
    case (c)
      6'h00: return st.run_cmd || st.out_freq != '0;
      6'h01: return st.fault_active && !st.comm_error_first && !st.comm_error_second;
      6'h02: return st.out_freq <= st.freq_ref
        && 15'(st.out_freq) + 15'(RST_WIDTH) >= 15'(st.freq_ref);
      6'h03: return 15'(st.out_freq) <= 15'(RST_LEVEL) + 15'(RST_WIDTH);
      6'h04: return det_m || 15'(st.out_freq) >= 15'(RST_LEVEL) + 15'(RST_WIDTH);
      6'h05: return !(det_m || 15'(st.out_freq) >= 15'(RST_LEVEL) + 15'(RST_WIDTH));
      6'h06: return st.auto_restart;
      6'h09: return st.output_blocked;
      6'h0c: return st.over_torque;
      6'h19: return st.under_torque;
      6'h12: return cfg[1:0] == SRC_PLC;
      6'h13: return st.plc_result;
      6'h14: return st.out_freq < st.min_freq;
      6'h15: return !st.fault_active && st.drive_ready;
      6'h16: return st.dc_bus < lv;
      6'h17: return cfg[1:0] == SRC_LOCAL || st.local_remote_in;
      6'h18: return cfg[3:2] == SRC_LOCAL || st.local_remote_in;
      6'h1a: return st.ref_loss;
      6'h1c: return st.traverse_up;
      6'h1d: return st.traverse_on;
      6'h1e: return st.motor2_sel;
      6'h1f: return st.zero_servo_done;
      6'h20: return comm[0];
      default: return 1'b0;
    endcase
  endfunction : f0

  // monitors take the oldest note when a result appears
  always @(posedge clk) begin
    if (apb_req.psel && apb_req.penable && pready && !apb_req.pwrite)
      cmp_rd(rd_q.pop_front(), {pslverr, prdata});
  end
  always @(chk_ev) cmp_out(out_q.pop_front(), {loss_stop_req, out_contact});

  // main sequence
  initial begin
    void'($urandom(32'h3397));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_SEL0, {27'h0, RST_SEL});
    rd(OFS_FDET_WIDTH, {25'h0, RST_WIDTH});
    rd(OFS_LOSS_PCT, {26'h0, RST_PCT});
    rd(8'h3c, {1'b1, 32'h0});
    rd(8'h05, {1'b1, 32'h0});
    apb(1'b1, OFS_SEL1, 32'h0);
    apb(1'b1, OFS_SEL2, 32'h7);
    repeat (3) foreach (CODES[i]) begin
      cfg = 5'($urandom);
      lv = 12'($urandom);
      comm = 3'($urandom);
      apb(1'b1, OFS_SEL0, {26'h0, CODES[i]});
      apb(1'b1, OFS_SRC_CFG, {27'h0, cfg});
      apb(1'b1, OFS_LV_LEVEL, {20'h0, lv});
      apb(1'b1, OFS_COMM_DO, {29'h0, comm});
      rn = {$urandom, $urandom, $urandom};
      nx = rn[$bits(dos_status_t)-1:0];
      nx.out_freq = nx.freq_ref - 14'($urandom_range(30));
      st <= nx;
      repeat (2) @(posedge clk);
      out_q.push_back({!cfg[SRC_LOSS_BIT] && st.ref_loss, 1'b0,
        st.run_cmd || st.out_freq != '0, f0(CODES[i])});
      // level stays at reset, so the hysteresis state only ever sets
      det_m = det_m || 15'(st.out_freq) >= 15'(RST_LEVEL) + 15'(RST_WIDTH);
      lref_exp = (st.ref_loss && cfg[SRC_LOSS_BIT]) ? last_ref : st.freq_ref;
      if (!st.ref_loss) last_ref = st.freq_ref;
      @(negedge clk);
      ->chk_ev;
      @(posedge clk);
      rd(OFS_LOSS_REF, {19'h0, lref_exp});
    end
    end_sim();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule : dos_select_test
